//--- rtl/qsb_pkg.sv
/*
 * Shared constants and carrier types for the four-channel serial bus
 * interface. Assumes a 16-bit multiplexed backplane with octal-style
 * peripheral addressing and one UART per channel beside this block.
 */
package qsb_pkg;

    localparam int NUM_CH   = 4;
    localparam int NUM_SRC  = 8;
    localparam int DW       = 16;

    // Register select, address bits 2:1.
    localparam logic [1:0] REG_RX_CSR = 2'h0;
    localparam logic [1:0] REG_RX_BUF = 2'h1;
    localparam logic [1:0] REG_TX_CSR = 2'h2;
    localparam logic [1:0] REG_TX_BUF = 2'h3;

    // Address field positions.
    localparam int ADR_REG_LO  = 1;
    localparam int ADR_CH_LO   = 3;
    localparam int ADR_BASE_LO = 5;
    localparam int ADR_BASE_HI = 12;

    // Console block 177560..177566, compared on address bits 12:3.
    localparam logic [9:0] CONS_ADR_HI = 10'h3ee;
    localparam logic [1:0] CONS_CH     = 2'h3;

    // Control and status bit positions, shared by both CSRs.
    localparam int CSR_DONE = 7;
    localparam int CSR_IE   = 6;
    localparam int CSR_CMD  = 0;

    // Receive buffer error bits.
    localparam int BUF_ERR = 15;
    localparam int BUF_OVR = 14;
    localparam int BUF_FER = 13;
    localparam int BUF_PER = 12;

    // Vector layout and the fixed console vectors.
    localparam int VEC_DIR     = 2;
    localparam int VEC_CH_LO   = 3;
    localparam int VEC_BASE_LO = 5;
    localparam int VEC_SW_W    = 4;
    localparam logic [15:0] CONS_VEC_RX = 16'h0030;
    localparam logic [15:0] CONS_VEC_TX = 16'h0034;

    typedef struct packed {
        logic [1:0] len;      // 0:5 bits, 1:6, 2:7, 3:8
        logic       par_en;
        logic       par_odd;
        logic       two_stop;
    } qsb_fmt_t;

    typedef struct packed {
        logic       valid;    // One-cycle pulse when a character completes.
        logic [7:0] data;
        logic       parity;   // Parity bit as received.
        logic       stop_ok;
    } qsb_rx_char_t;

endpackage

//--- rtl/qsb_serial_bus_rx.sv
/*
 * Bus side of a four-channel serial line interface: address decode,
 * register file, receive status and buffer, interrupt priority and
 * vector supply. Assumes the bus pins are already synchronous to
 * sys_clk and active high, and that the UARTs deliver whole characters.
 */
`timescale 1ns/1ps

module qsb_serial_bus_rx #(
    parameter int SW_W = qsb_pkg::VEC_SW_W
) (
    input  wire logic                  sys_clk,
    input  wire logic                  srst,
    input  wire logic [15:0]           bdal_in,
    output logic      [15:0]           bdal_out,
    output logic                       bdal_oe,
    input  wire logic                  bsync,
    input  wire logic                  bdin,
    input  wire logic                  bdout,
    input  wire logic                  bbs7,
    input  wire logic                  binit,
    input  wire logic                  biak_in,
    output logic                       biak_out,
    output logic                       birq,
    output logic                       bus_reply_strobe,
    input  wire logic [7:0]            address_base_switches,
    input  wire logic [SW_W-1:0]       vector_base_switches,
    input  wire logic                  console_mode,
    input  wire qsb_pkg::qsb_fmt_t     fmt [qsb_pkg::NUM_CH],
    input  wire qsb_pkg::qsb_rx_char_t rx_char [qsb_pkg::NUM_CH],
    input  wire logic [3:0]            tx_ready,
    output logic      [3:0]            reader_advance,
    output logic      [3:0]            tx_break,
    output logic      [3:0]            tx_load,
    output logic      [7:0]            tx_data
);

    ////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        logic        sync_q;
        logic        sel;
        logic [1:0]  ch;
        logic [1:0]  rsel;
        logic        reply;
        logic        oe;
        logic [15:0] dout;
        logic        iak_busy;
        logic [3:0]  done;
        logic [3:0]  rx_ie;
        logic [3:0]  tx_ie;
        logic [3:0]  brk;
        logic [3:0]  ovr;
        logic [3:0]  fer;
        logic [3:0]  per;
        logic [31:0] data;
        logic [7:0]  arm;     // Previous flag-and-enable, for edge start.
        logic [7:0]  req;     // 7..4 receivers ch4..1, 3..0 transmitters.
        logic [3:0]  adv;
        logic [3:0]  load;
        logic [7:0]  txd;
    } qsb_state_t;

    qsb_state_t st_q;
    qsb_state_t st_d;

    logic [7:0]  flag;
    logic        hit;
    logic [1:0]  hit_ch;
    logic [2:0]  win;
    logic [15:0] vec;
    logic [15:0] rdata;

    ////////////////////////////////////////////////////////////////////////
    // Address decode on the leading edge of the address strobe.

    always_comb begin
        logic cons_hit;
        logic blk_hit;
        cons_hit = 1'b0;
        blk_hit  = 1'b0;
        cons_hit = console_mode && bbs7 &&
                   bdal_in[12:3] == qsb_pkg::CONS_ADR_HI;
        blk_hit  = bbs7 && bdal_in[qsb_pkg::ADR_BASE_HI:
                                   qsb_pkg::ADR_BASE_LO]
                   == address_base_switches;
        // In console mode the last channel leaves the switch block.
        if (console_mode &&
            bdal_in[qsb_pkg::ADR_CH_LO +: 2] == qsb_pkg::CONS_CH) begin
            blk_hit = 1'b0;
        end
        hit    = cons_hit || blk_hit;
        hit_ch = cons_hit ? qsb_pkg::CONS_CH
                          : bdal_in[qsb_pkg::ADR_CH_LO +: 2];
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt sources, priority and vector.

    always_comb begin
        for (int c = 0; c < qsb_pkg::NUM_CH; c++) begin
            flag[4 + c] = st_q.done[c] && st_q.rx_ie[c];
            flag[c]     = tx_ready[c] && st_q.tx_ie[c];
        end
    end

    always_comb begin
        win = 3'h0;
        // Highest index wins: receivers ch4..1, then transmitters.
        for (int s = 0; s < qsb_pkg::NUM_SRC; s++) begin
            if (st_q.req[s]) begin
                win = 3'(s);
            end
        end
    end

    always_comb begin
        vec = '0;
        vec[qsb_pkg::VEC_BASE_LO +: SW_W] = vector_base_switches;
        vec[qsb_pkg::VEC_CH_LO +: 2]      = win[1:0];
        vec[qsb_pkg::VEC_DIR]             = ~win[2];
        if (console_mode && win[1:0] == qsb_pkg::CONS_CH) begin
            vec = win[2] ? qsb_pkg::CONS_VEC_RX
                         : qsb_pkg::CONS_VEC_TX;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read mux.

    always_comb begin
        logic [7:0] d;
        d     = st_q.data[st_q.ch*8 +: 8];
        rdata = '0;
        case (st_q.rsel)
            qsb_pkg::REG_RX_CSR: begin
                rdata[qsb_pkg::CSR_DONE] = st_q.done[st_q.ch];
                rdata[qsb_pkg::CSR_IE]   = st_q.rx_ie[st_q.ch];
            end
            qsb_pkg::REG_RX_BUF: begin
                rdata[7:0] = d;
                rdata[qsb_pkg::BUF_OVR] = st_q.ovr[st_q.ch];
                rdata[qsb_pkg::BUF_FER] = st_q.fer[st_q.ch];
                rdata[qsb_pkg::BUF_PER] = st_q.per[st_q.ch];
                rdata[qsb_pkg::BUF_ERR] = st_q.ovr[st_q.ch] |
                                          st_q.fer[st_q.ch] |
                                          st_q.per[st_q.ch];
            end
            qsb_pkg::REG_TX_CSR: begin
                rdata[qsb_pkg::CSR_DONE] = tx_ready[st_q.ch];
                rdata[qsb_pkg::CSR_IE]   = st_q.tx_ie[st_q.ch];
                rdata[qsb_pkg::CSR_CMD]  = st_q.brk[st_q.ch];
            end
            default: begin
                rdata = '0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb begin
        logic [7:0] mask;
        logic       nparity;
        st_d       = st_q;
        mask       = 8'h00;
        nparity    = 1'b0;
        st_d.adv   = '0;
        st_d.load  = '0;
        st_d.sync_q = bsync;

        // Bus cycle framing and slave transfer.
        if (bsync && !st_q.sync_q) begin
            st_d.sel  = hit;
            st_d.ch   = hit_ch;
            st_d.rsel = bdal_in[qsb_pkg::ADR_REG_LO +: 2];
        end
        if (!bsync) begin
            st_d.sel = 1'b0;
        end

        if (st_q.sel && bdin && !st_q.reply) begin
            st_d.reply = 1'b1;
            st_d.oe    = 1'b1;
            st_d.dout  = rdata;
            if (st_q.rsel == qsb_pkg::REG_RX_BUF) begin
                st_d.done[st_q.ch] = 1'b0;
            end
        end
        if (st_q.sel && bdout && !st_q.reply) begin
            st_d.reply = 1'b1;
            case (st_q.rsel)
                qsb_pkg::REG_RX_CSR: begin
                    st_d.rx_ie[st_q.ch] = bdal_in[qsb_pkg::CSR_IE];
                    if (bdal_in[qsb_pkg::CSR_CMD]) begin
                        st_d.adv[st_q.ch]  = 1'b1;
                        st_d.done[st_q.ch] = 1'b0;
                    end
                end
                qsb_pkg::REG_TX_CSR: begin
                    st_d.tx_ie[st_q.ch] = bdal_in[qsb_pkg::CSR_IE];
                    st_d.brk[st_q.ch]   = bdal_in[qsb_pkg::CSR_CMD];
                end
                qsb_pkg::REG_TX_BUF: begin
                    st_d.load[st_q.ch] = 1'b1;
                    st_d.txd           = bdal_in[7:0];
                end
                default: begin
                    st_d.reply = 1'b1;
                end
            endcase
        end

        // Interrupt acknowledge: serve the single winning source.
        if (!bsync && bdin && biak_in && !st_q.iak_busy &&
            |st_q.req) begin
            st_d.iak_busy  = 1'b1;
            st_d.reply     = 1'b1;
            st_d.oe        = 1'b1;
            st_d.dout      = vec;
            st_d.req[win]  = 1'b0;
        end
        if (!biak_in && !bdin) begin
            st_d.iak_busy = 1'b0;
        end
        if (!bdin && !bdout) begin
            st_d.reply = 1'b0;
            st_d.oe    = 1'b0;
        end

        // Requests start on the rising edge of flag-and-enable only.
        st_d.arm = flag;
        for (int s = 0; s < qsb_pkg::NUM_SRC; s++) begin
            if (!flag[s]) begin
                st_d.req[s] = 1'b0;
            end else if (!st_q.arm[s]) begin
                st_d.req[s] = 1'b1;
            end
        end

        // Character completion; a new character wins over a same-cycle
        // bus clear, but binit wins over it. Overrun is set by any completion that finds done still set,
        // however soon after the previous character it arrives.
        for (int c = 0; c < qsb_pkg::NUM_CH; c++) begin
            if (rx_char[c].valid) begin
                mask = 8'hff >> (2'h3 - fmt[c].len);
                st_d.data[c*8 +: 8] = rx_char[c].data & mask;
                nparity = ^(rx_char[c].data & mask) ^ rx_char[c].parity;
                st_d.ovr[c]  = st_q.done[c];
                st_d.fer[c]  = !rx_char[c].stop_ok;
                st_d.per[c]  = fmt[c].par_en &&
                               (nparity != fmt[c].par_odd);
                st_d.done[c] = 1'b1;
            end
        end

        if (binit) begin
            st_d.done  = '0;
            st_d.rx_ie = '0;
            st_d.tx_ie = '0;
            st_d.brk   = '0;
            st_d.ovr   = '0;
            st_d.fer   = '0;
            st_d.per   = '0;
            st_d.req   = '0;
            st_d.arm   = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////

    assign bdal_out         = st_q.dout;
    assign bdal_oe          = st_q.oe;
    assign bus_reply_strobe = st_q.reply;
    assign birq             = |st_q.req;
    // Grant passes on only when nothing here is pending or being served.
    assign biak_out         = biak_in && !(|st_q.req) && !st_q.iak_busy;
    assign reader_advance   = st_q.adv;
    assign tx_break         = st_q.brk;
    assign tx_load          = st_q.load;
    assign tx_data          = st_q.txd;

endmodule

//--- bench/qsb_sva.sv
/*
 * Concurrent checks on the bus side of the serial interface block.
 * Assumes only the top module's ports, sampled on sys_clk.
 */
`timescale 1ns/1ps

module qsb_sva #(
    parameter int SW_W = qsb_pkg::VEC_SW_W
) (
    input wire logic            sys_clk,
    input wire logic            srst,
    input wire logic            bsync,
    input wire logic            bdin,
    input wire logic            bdout,
    input wire logic            biak_in,
    input wire logic            biak_out,
    input wire logic            birq,
    input wire logic            bus_reply_strobe,
    input wire logic            bdal_oe,
    input wire logic [15:0]     bdal_out,
    input wire logic [SW_W-1:0] vector_base_switches,
    input wire logic            console_mode,
    input wire logic [3:0]      reader_advance,
    input wire logic [3:0]      tx_load
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);

    a_reply_cause: assert property (
        $rose(bus_reply_strobe) |-> $past(bdin) || $past(bdout))
        else $error("reply without a data strobe");
    a_reply_drop: assert property (
        bus_reply_strobe && !bdin && !bdout |=> !bus_reply_strobe)
        else $error("reply held after strobes fell");
    a_drive_replied: assert property (
        bdal_oe |-> bus_reply_strobe)
        else $error("bus driven without reply");
    a_vec_range: assert property (
        $rose(bus_reply_strobe) && !bsync && biak_in
        |-> bdal_out[15:9] == 7'h0 && bdal_out[1:0] == 2'h0)
        else $error("vector out of range");
    a_vec_base: assert property (
        $rose(bus_reply_strobe) && !bsync && biak_in
        |-> console_mode || bdal_out[8:5] == vector_base_switches)
        else $error("vector base differs from switches");
    a_grant_hold: assert property (
        birq |-> !biak_out)
        else $error("grant passed on while requesting");
    a_grant_pass: assert property (
        biak_out |-> biak_in)
        else $error("grant passed on without grant");
    a_advance_pulse: assert property (
        reader_advance != 4'h0 |=> reader_advance == 4'h0)
        else $error("reader advance longer than one cycle");
    a_load_cause: assert property (
        tx_load != 4'h0 |-> $past(bdout))
        else $error("transmit load without a write");
endmodule

bind qsb_serial_bus_rx qsb_sva #(.SW_W(SW_W)) sva_i (
    .sys_clk(sys_clk), .srst(srst), .bsync(bsync), .bdin(bdin),
    .bdout(bdout), .biak_in(biak_in), .biak_out(biak_out), .birq(birq),
    .bus_reply_strobe(bus_reply_strobe), .bdal_oe(bdal_oe),
    .bdal_out(bdal_out), .vector_base_switches(vector_base_switches),
    .console_mode(console_mode), .reader_advance(reader_advance),
    .tx_load(tx_load));

//--- bench/qsb_host.sv
/*
 * Processor model on the backplane: word transfers and acknowledge.
 * Assumes the device answers within 20 cycles of each strobe.
 */
`timescale 1ns/1ps

module qsb_host (
    input  wire logic        sys_clk,
    input  wire logic [15:0] bdal_out,
    input  wire logic        bus_reply_strobe,
    output logic      [15:0] bdal_in,
    output logic             bsync,
    output logic             bdin,
    output logic             bdout,
    output logic             bbs7,
    output logic             biak_in
);
    int tmo = 0;

    initial begin
        bdal_in = 16'h0;
        {bsync, bdin, bdout, bbs7, biak_in} = 5'h0;
    end

    // Values are taken at the rising edge, before that edge's updates.
    task automatic wait_rep(input logic lvl, output logic ok);
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (bus_reply_strobe !== lvl && n < 20);
        ok = (bus_reply_strobe === lvl);
    endtask

    // A released bus shows the data-phase pattern inverted, which after a read is the address again.
    task automatic xfer(input logic [15:0] a, input logic w,
                        input logic [15:0] wd, output logic [15:0] rd,
                        output logic ok);
        logic dn;
        @(negedge sys_clk);
        bdal_in = a;
        {bsync, bbs7} = 2'h3;
        @(negedge sys_clk);
        bdal_in = w ? wd : ~a;
        {bdin, bdout} = {!w, w};
        wait_rep(1'b1, ok);
        rd = bdal_out;
        @(negedge sys_clk);
        {bdin, bdout} = 2'h0;
        bdal_in = ~bdal_in;
        wait_rep(1'b0, dn);
        if (!dn) tmo++;
        @(negedge sys_clk);
        {bsync, bbs7} = 2'h0;
    endtask

    task automatic iack(output logic [15:0] v);
        logic ok;
        @(negedge sys_clk);
        {bdin, biak_in} = 2'h3;
        wait_rep(1'b1, ok);
        v = ok ? bdal_out : 16'hffff;
        @(negedge sys_clk);
        {bdin, biak_in} = 2'h0;
        wait_rep(1'b0, ok);
        if (!ok) tmo++;
    endtask
endmodule

//--- bench/quad_serial_bus_interface_rx_test.sv
/*
 * Self-checking bench for the serial interface bus side.
 * Assumes the processor model qsb_host and the bound checker.
 */
`timescale 1ns/1ps

module quad_serial_bus_interface_rx_test;
    logic                  sys_clk, srst, binit, console_mode;
    logic [15:0]           bdal_in, bdal_out;
    logic                  bdal_oe, bsync, bdin, bdout, bbs7;
    logic                  biak_in, biak_out, birq, rep;
    logic [3:0]            tx_ready, reader_advance, tx_break, tx_load;
    logic [7:0]            tx_data;
    logic                  adv_seen = 1'b0;
    logic                  load_seen = 1'b0;
    logic [3:0]            vec_sw = 4'h5;
    qsb_pkg::qsb_fmt_t     fmt [qsb_pkg::NUM_CH];
    qsb_pkg::qsb_rx_char_t rx_char [qsb_pkg::NUM_CH];
    int                    err_count = 0;
    int                    comparisons = 0;

    qsb_host host (.sys_clk(sys_clk), .bdal_out(bdal_out),
        .bus_reply_strobe(rep), .bdal_in(bdal_in), .bsync(bsync),
        .bdin(bdin), .bdout(bdout), .bbs7(bbs7), .biak_in(biak_in));

    qsb_serial_bus_rx uut (.sys_clk(sys_clk), .srst(srst),
        .bdal_in(bdal_in), .bdal_out(bdal_out), .bdal_oe(bdal_oe),
        .bsync(bsync), .bdin(bdin), .bdout(bdout), .bbs7(bbs7),
        .binit(binit), .biak_in(biak_in), .biak_out(biak_out),
        .birq(birq), .bus_reply_strobe(rep),
        .address_base_switches(8'h10), .vector_base_switches(vec_sw),
        .console_mode(console_mode), .fmt(fmt), .rx_char(rx_char),
        .tx_ready(tx_ready), .reader_advance(reader_advance),
        .tx_break(tx_break), .tx_load(tx_load), .tx_data(tx_data));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Both strobes last one cycle, so they are caught as they happen.
    always @(posedge sys_clk) begin
        if (reader_advance[3] === 1'b1) adv_seen <= 1'b1;
        if (tx_load[1] === 1'b1) load_seen <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] adr(input int c, input int r);
        return {3'h7, 8'h10, c[1:0], r[1:0], 1'b0};
    endfunction

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("wrong value at %0t: got %h exp %h", $time, g, e);
        end
    endtask

    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        logic [15:0] d;
        logic        ok;
        host.xfer(a, 1'b0, 16'h0, d, ok);
        chk(ok ? d : 16'hdead, e);
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        logic [15:0] d;
        logic        ok;
        host.xfer(a, 1'b1, v, d, ok);
        chk({15'h0, ok}, 16'h0001);
    endtask

    // An address outside the decoded set must never be answered.
    task automatic none(input logic [15:0] a);
        logic [15:0] d;
        logic        ok;
        host.xfer(a, 1'b0, 16'h0, d, ok);
        chk({15'h0, ok}, 16'h0000);
    endtask

    task automatic ack(input logic [15:0] e);
        logic [15:0] v;
        host.iack(v);
        chk(v, e);
    endtask

    task automatic rx(input int c, input logic [7:0] d, input logic p,
                      input logic s);
        @(negedge sys_clk);
        rx_char[c] = {1'b1, d, p, s};
        @(negedge sys_clk);
        rx_char[c].valid = 1'b0;
    endtask

    task automatic end_of_test;
        err_count += host.tmo;
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge sys_clk);
        err_count++;
        end_of_test;
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {srst, binit, console_mode} = 3'h4;
        tx_ready = 4'h2;
        for (int c = 0; c < 4; c++) begin
            fmt[c] = 5'h18;
            rx_char[c] = 11'h0;
        end
        repeat (3) @(negedge sys_clk);
        srst = 1'b0;
        rd(adr(0, 0), 16'h0000);
        none(16'he220);
        fmt[0] = 5'h19;
        rx(0, 8'h41, 1'b0, 1'b0);
        rd(adr(0, 0), 16'h0080);
        rd(adr(0, 1), 16'ha041);
        rd(adr(0, 0), 16'h0000);
        rx(0, 8'h11, 1'b0, 1'b1);
        rx(0, 8'h22, 1'b0, 1'b1);
        rd(adr(0, 1), 16'hc022);
        rx(0, 8'h33, 1'b0, 1'b1);
        rd(adr(0, 1), 16'h0033);
        for (int l = 0; l < 4; l++) begin
            fmt[1] = {l[1:0], 3'h0};
            rx(1, 8'hff, 1'b0, 1'b1);
            rd(adr(1, 1), 16'h00ff >> (3 - l));
        end
        for (int m = 0; m < 6; m++) begin
            fmt[2] = {2'h3, m > 1, m > 3, 1'b0};
            rx(2, 8'h03, m[0], 1'b1);
            rd(adr(2, 1), (m > 1 && m[0] != (m > 3)) ?
               16'h9003 : 16'h0003);
        end
        rx(3, 8'h07, 1'b0, 1'b1);
        wr(adr(3, 0), 16'h0001);
        chk({15'h0, adv_seen}, 16'h0001);
        rd(adr(3, 0), 16'h0000);
        wr(adr(1, 3), 16'h00a5);
        chk({8'h0, tx_data}, 16'h00a5);
        chk({15'h0, load_seen}, 16'h0001);
        rd(adr(1, 2), 16'h0080);
        wr(adr(2, 2), 16'h0001);
        chk({12'h0, tx_break}, 16'h0004);
        rd(adr(2, 2), 16'h0001);
        wr(adr(0, 0), 16'h0040);
        wr(adr(3, 0), 16'h0040);
        rd(adr(0, 0), 16'h0040);
        wr(adr(1, 2), 16'h0040);
        rx(0, 8'h01, 1'b0, 1'b1);
        rx(3, 8'h02, 1'b0, 1'b1);
        ack(16'h00b8);
        ack(16'h00a0);
        ack(16'h00ac);
        ack(16'hffff);
        rd(adr(0, 1), 16'h0001);
        vec_sw = 4'ha;
        rx(0, 8'h04, 1'b0, 1'b1);
        ack(16'h0140);
        @(negedge sys_clk);
        console_mode = 1'b1;
        rd(16'hff70, 16'h00c0);
        none(adr(3, 0));
        @(negedge sys_clk);
        binit = 1'b1;
        @(negedge sys_clk);
        binit = 1'b0;
        chk({12'h0, tx_break}, 16'h0000);
        rd(16'hff70, 16'h0000);
        rd(adr(0, 0), 16'h0000);
        wr(16'hff70, 16'h0040);
        rx(3, 8'h09, 1'b0, 1'b1);
        ack(16'h0030);
        rd(16'hff72, 16'h0009);
        end_of_test;
    end
endmodule
